// file: verilog/asr_pkg.sv
`default_nettype none
package asr_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ASR_OFS_CTRL = 8'h00;
  localparam logic [7:0] ASR_OFS_STATUS = 8'h04;
  localparam logic [7:0] ASR_OFS_DATA = 8'h08;
  localparam logic [7:0] ASR_OFS_BAUD = 8'h0c;
  localparam logic [7:0] ASR_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] ASR_OFS_IRQ_MASK = 8'h14;

  // ctrl fields
  localparam int ASR_CTRL_EN = 0;
  localparam int ASR_CTRL_SYNC = 1;
  localparam int ASR_CTRL_SERIAL_PORT_ENABLE = 2;
  localparam int ASR_CTRL_INV = 3;
  localparam int ASR_CTRL_NINE = 4;
  localparam int ASR_CTRL_W = 5;
  localparam logic [4:0] ASR_CTRL_RST = 5'h00;

  // status fields (read only)
  localparam int ASR_ST_AVAIL = 0;
  localparam int ASR_ST_FERR = 1;
  localparam int ASR_ST_OVR = 2;
  localparam int ASR_ST_FULL = 3;
  localparam int ASR_ST_BUSY = 4;

  // interrupt status / mask fields
  localparam int ASR_IRQ_CHAR = 0;
  localparam int ASR_IRQ_FERR = 1;
  localparam int ASR_IRQ_OVR = 2;
  localparam int ASR_IRQ_W = 3;
  localparam logic [2:0] ASR_IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ASR_DIV_W = 16;
  localparam logic [15:0] ASR_BAUD_RST = 16'h0040;
  localparam logic [3:0] ASR_OVS_LAST = 4'hf;
  localparam logic [3:0] ASR_HALF_BIT = 4'h7;
  localparam logic [3:0] ASR_VOTE_A = 4'hd;
  localparam logic [3:0] ASR_VOTE_B = 4'he;
  localparam logic [3:0] ASR_BITS_8 = 4'h8;
  localparam logic [3:0] ASR_BITS_9 = 4'h9;
  localparam int ASR_CHAR_W = 9;
  localparam int ASR_FIFO_DEPTH = 2;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_START = 2'b01,
    ASR_DATA = 2'b11,
    ASR_STOP = 2'b10
  } asr_state_e;
endpackage
`default_nettype wire

// file: verilog/asr_rx_if.sv
`default_nettype none
interface asr_rx_if;
  import asr_pkg::*;
  logic enable;
  logic invert;
  logic nine;
  logic [ASR_DIV_W-1:0] div;
  logic push;
  logic [ASR_CHAR_W-1:0] data;
  logic ferr;
  logic busy;
  modport core (input enable, invert, nine, div,
                output push, data, ferr, busy);
  modport ctl (output enable, invert, nine, div,
               input push, data, ferr, busy);
endinterface
`default_nettype wire

// file: verilog/asr_rx_core.sv
`default_nettype none
module asr_rx_core
  import asr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial line
  input wire logic rx_pin,
  // control and character out
  asr_rx_if.core rif
);
  asr_state_e state;
  logic [ASR_DIV_W-1:0] div_cnt;
  logic tick;
  logic line;
  logic line_q;
  logic [3:0] ovs;
  logic [3:0] nbits;
  logic [ASR_CHAR_W-1:0] shreg;
  logic vote_a;
  logic vote_b;
  logic vote;

  // ----------------------------------------------------------------
  // oversampling tick
  // ----------------------------------------------------------------
  // sixteen x tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (!rif.enable || div_cnt >= rif.div) begin
      div_cnt <= '0;
      tick <= rif.enable;
    end else begin
      div_cnt <= div_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line <= 1'b1;
      line_q <= 1'b1;
    end else if (tick) begin
      line <= rx_pin ^ rif.invert;
      line_q <= line;
    end
  end

  assign vote = (vote_a & vote_b) | (vote_a & line) | (vote_b & line);

  // ----------------------------------------------------------------
  // receive sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ASR_IDLE;
      ovs <= '0;
      nbits <= '0;
      shreg <= '0;
      vote_a <= 1'b1;
      vote_b <= 1'b1;
      rif.push <= 1'b0;
      rif.data <= '0;
      rif.ferr <= 1'b0;
    end else begin
      rif.push <= 1'b0;
      if (!rif.enable) begin
        state <= ASR_IDLE;
      end else if (tick) begin
        ovs <= ovs + 1'b1;
        if (ovs == ASR_VOTE_A) begin
          vote_a <= line;
        end
        if (ovs == ASR_VOTE_B) begin
          vote_b <= line;
        end
        case (state)
          ASR_IDLE: begin
            if (line_q && !line) begin
              state <= ASR_START;
              ovs <= '0;
            end
          end
          ASR_START: begin
            if (ovs == ASR_HALF_BIT) begin
              ovs <= '0;
              nbits <= '0;
              state <= line ? ASR_IDLE : ASR_DATA;
            end
          end
          ASR_DATA: begin
            if (ovs == ASR_OVS_LAST) begin
              shreg <= {vote, shreg[ASR_CHAR_W-1:1]};
              nbits <= nbits + 1'b1;
              if (nbits + 1'b1 == (rif.nine ? ASR_BITS_9 : ASR_BITS_8)) begin
                state <= ASR_STOP;
              end
            end
          end
          ASR_STOP: begin
            if (ovs == ASR_OVS_LAST) begin
              rif.ferr <= !vote;
              rif.push <= 1'b1;
              rif.data <= rif.nine ? shreg : {1'b0, shreg[ASR_CHAR_W-1:1]};
              state <= ASR_IDLE;
            end
          end
          default: state <= ASR_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rif.busy <= 1'b0;
    end else begin
      rif.busy <= (state != ASR_IDLE);
    end
  end
endmodule
`default_nettype wire

// file: verilog/asr_top.sv
// Operation
// - line oversampled sixteen times per bit
// - finished character goes straight into fifo
// - data register read pops oldest character
// - receive needs enable, async, port enable
// - falling edge starts a character
// - half bit recheck, silent abort
// - majority sample at each bit centre
// - stop zero flags framing error
// - push and raise character flag together
// - overrun blocks reception until cleared
// - polarity bit resets zero, inverts line
// - inversion applies only in async mode
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter int DEPTH = ASR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line and interrupt
  input wire logic rx_pin,
  output logic irq
);
  asr_rx_if rif ();

  logic [ASR_CTRL_W-1:0] ctrl;
  logic [ASR_DIV_W-1:0] baud;
  logic [ASR_IRQ_W-1:0] irq_stat;
  logic [ASR_IRQ_W-1:0] irq_mask;
  logic [ASR_CHAR_W-1:0] fifo_data [DEPTH];
  logic fifo_ferr [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  logic [$clog2(DEPTH):0] count;
  logic overrun;
  logic rx_on;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_data;
  logic pop;
  logic rd_ok;
  logic accept;
  logic full;
  logic empty;
  logic mapped;
  logic [31:0] next_prdata;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite && !pslverr;
  assign rd_data = access && !pwrite && paddr == ASR_OFS_DATA;
  assign mapped = paddr == ASR_OFS_CTRL || paddr == ASR_OFS_STATUS ||
                  paddr == ASR_OFS_DATA || paddr == ASR_OFS_BAUD ||
                  paddr == ASR_OFS_IRQ_STAT || paddr == ASR_OFS_IRQ_MASK;
  assign full = count == DEPTH[$clog2(DEPTH):0];
  assign empty = count == '0;

  // read returns and removes oldest
  // pop only what setup returned; a push landing on the setup edge
  // would otherwise be removed unseen
  assign pop = rd_data && rd_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ok <= 1'b0;
    end else if (setup) begin
      rd_ok <= !empty;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      ASR_OFS_CTRL: next_prdata[ASR_CTRL_W-1:0] = ctrl;
      ASR_OFS_STATUS: begin
        next_prdata[ASR_ST_AVAIL] = !empty;
        next_prdata[ASR_ST_FERR] = !empty && fifo_ferr[rd_ptr];
        next_prdata[ASR_ST_OVR] = overrun;
        next_prdata[ASR_ST_FULL] = full;
        next_prdata[ASR_ST_BUSY] = rif.busy;
      end
      ASR_OFS_DATA: begin
        if (!empty) begin
          next_prdata[ASR_CHAR_W-1:0] = fifo_data[rd_ptr];
        end
      end
      ASR_OFS_BAUD: next_prdata[ASR_DIV_W-1:0] = baud;
      ASR_OFS_IRQ_STAT: next_prdata[ASR_IRQ_W-1:0] = irq_stat;
      ASR_OFS_IRQ_MASK: next_prdata[ASR_IRQ_W-1:0] = irq_mask;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // one wait-free access phase; answer is registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // polarity resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ASR_CTRL_RST;
    end else if (wr_en && paddr == ASR_OFS_CTRL) begin
      ctrl <= pwdata[ASR_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud <= ASR_BAUD_RST;
    end else if (wr_en && paddr == ASR_OFS_BAUD) begin
      baud <= pwdata[ASR_DIV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= ASR_IRQ_MASK_RST;
    end else if (wr_en && paddr == ASR_OFS_IRQ_MASK) begin
      irq_mask <= pwdata[ASR_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // receiver hookup
  // ----------------------------------------------------------------
  // three enables together
  assign rx_on = ctrl[ASR_CTRL_EN] && !ctrl[ASR_CTRL_SYNC] &&
                 ctrl[ASR_CTRL_SERIAL_PORT_ENABLE];
  assign rif.enable = rx_on && !overrun;
  assign rif.invert = ctrl[ASR_CTRL_INV] && !ctrl[ASR_CTRL_SYNC];
  assign rif.nine = ctrl[ASR_CTRL_NINE];
  assign rif.div = baud;

  asr_rx_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .rx_pin(rx_pin),
    .rif(rif.core)
  );

  // ----------------------------------------------------------------
  // two character fifo
  // ----------------------------------------------------------------
  // room freed by a pop in the same cycle counts
  assign accept = rif.push && (!full || pop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        fifo_data[i] <= '0;
        fifo_ferr[i] <= 1'b0;
      end
    end else if (accept) begin
      fifo_data[wr_ptr] <= rif.data;
      fifo_ferr[wr_ptr] <= rif.ferr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (accept) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (accept && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !accept) begin
        count <= count - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // overrun and interrupts
  // ----------------------------------------------------------------
  // overrun latch; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (rif.push && !accept) begin
      overrun <= 1'b1;
    end else if (!ctrl[ASR_CTRL_EN] ||
                 (wr_en && paddr == ASR_OFS_IRQ_STAT &&
                  pwdata[ASR_IRQ_OVR])) begin
      overrun <= 1'b0;
    end
  end

  generate
    for (genvar b = 0; b < ASR_IRQ_W; b++) begin : g_irq
      logic ev;
      if (b == ASR_IRQ_CHAR) begin : g_c
        assign ev = accept;
      end else if (b == ASR_IRQ_FERR) begin : g_f
        assign ev = accept && rif.ferr;
      end else begin : g_o
        assign ev = rif.push && !accept;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_stat[b] <= 1'b0;
        end else if (ev) begin
          irq_stat[b] <= 1'b1;
        end else if (wr_en && paddr == ASR_OFS_IRQ_STAT && pwdata[b]) begin
          irq_stat[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule
`default_nettype wire

// file: verif/asr_properties.sv
`default_nettype none
module asr_properties
  import asr_pkg::*;
#(
  parameter int DEPTH = ASR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line and interrupt
  input wire logic rx_pin,
  input wire logic irq
);
  // ----
  // bus and interrupt checks
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic setup;
  logic mapped;
  logic wacc;
  assign setup = psel && !penable;
  assign mapped = paddr <= ASR_OFS_IRQ_MASK && paddr[1:0] == 2'b00;
  assign wacc = psel && penable && pready && pwrite;
  property p_ready;
    setup |=> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready missing after setup");
  property p_cause;
    pready |-> $past(setup);
  endproperty
  a_cause: assert property (p_cause)
    else $error("ready without setup");
  property p_single;
    pready |=> !pready;
  endproperty
  a_single: assert property (p_single)
    else $error("ready stood two cycles");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_unmapped;
    setup && !mapped |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mapped;
    setup && mapped |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
  property p_upper;
    pready |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  // irq only drops after a write clears or masks it
  property p_irq_fall;
    $fell(irq) |-> $past(wacc) || $past(wacc, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without write");
  c_char: cover property ($rose(irq));
  c_refuse: cover property (pslverr);
  c_write: cover property (wacc);
endmodule
bind asr_top asr_properties #(.DEPTH(DEPTH)) u_asr_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));
`default_nettype wire

// file: verif/asr_line_model.sv
`default_nettype none
module asr_line_model (
  // clock and line
  input wire logic pclk,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic inv = 1'b0;
  initial rx_pin = 1'b1;
  task automatic send(input logic [8:0] c, input int n,
                      input logic stp, input int bt);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge pclk);
      rx_pin <= inv ^ (i == 0 ? 1'b0 : i > n ? stp : c[i - 1]);
      repeat (bt - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_pin <= ~inv;
  endtask
  task automatic glitch(input int g);
    @(posedge pclk);
    rx_pin <= inv;
    repeat (g) @(posedge pclk);
    rx_pin <= ~inv;
  endtask
  task automatic set_inv(input logic v);
    @(posedge pclk);
    inv = v;
    rx_pin <= ~v;
  endtask
endmodule
`default_nettype wire

// file: verif/asr_bench.sv
`default_nettype none
module asr_bench
  import asr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 32;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_pin;
  logic irq;
  logic [31:0] q;
  logic err;
  logic [8:0] c [4];
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rv [6] = '{0, 0, 0, 32'(ASR_BAUD_RST), 0, 0};
  logic [31:0] dis [4] = '{32'h07, 32'h04, 32'h01, 32'h0f};
  int miscompares = 0;
  int checked = 0;
  always #50 pclk = ~pclk;
  asr_top u_asr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));
  asr_line_model u_asr_line_model (.pclk(pclk), .rx_pin(rx_pin));
  // ----
  // tasks
  // ----
  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) miscompares++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge keeps one assignment per step
    @(posedge pclk);
  endtask
  function automatic logic [31:0] mk(input logic [8:0] v, input int n);
    return n == 8 ? {24'h0, v[7:0]} : {23'h0, v};
  endfunction
  task automatic one(input int n, input logic stp);
    logic [8:0] v;
    v = 9'($urandom);
    u_asr_line_model.send(v, n, stp, BT);
    apb(1'b0, ASR_OFS_STATUS, 0);
    check("status", q, {30'h0, ~stp, 1'b1});
    apb(1'b0, ASR_OFS_IRQ_STAT, 0);
    check("irq_stat", q, {30'h0, ~stp, 1'b1});
    check("irq", {31'h0, irq}, 1);
    apb(1'b0, ASR_OFS_DATA, 0);
    check("data", q, mk(v, n));
    apb(1'b1, ASR_OFS_IRQ_STAT, 7);
    apb(1'b0, ASR_OFS_IRQ_STAT, 0);
    check("irq_clr", {31'h0, irq}, 0);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(47778));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 0);
      check("reset", q, rv[i]);
    end
    apb(1'b0, 8'h18, 0);
    check("unmapped", {q[30:0], err}, 1);
    apb(1'b1, ASR_OFS_BAUD, 1);
    apb(1'b1, ASR_OFS_IRQ_MASK, 7);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ASR_OFS_CTRL, dis[i]);
      u_asr_line_model.send(9'h055, 8, 1'b1, BT);
      apb(1'b0, ASR_OFS_IRQ_STAT, 0);
      check("disabled", q, 0);
    end
    apb(1'b1, ASR_OFS_CTRL, 5);
    u_asr_line_model.glitch(8);
    // long enough for a whole false character
    repeat (12 * BT) @(posedge pclk);
    apb(1'b0, ASR_OFS_STATUS, 0);
    check("glitch", q, 0);
    for (int i = 0; i < 4; i++) one(8, 1'b1);
    one(8, 1'b0);
    for (int i = 0; i < 4; i++) begin
      c[i] = 9'($urandom);
      u_asr_line_model.send(c[i], 8, 1'b1, BT);
    end
    apb(1'b0, ASR_OFS_STATUS, 0);
    check("overrun", q, 32'hd);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ASR_OFS_DATA, 0);
      check("fifo", q, i < 2 ? mk(c[i], 8) : 0);
    end
    apb(1'b1, ASR_OFS_IRQ_STAT, 7);
    one(8, 1'b1);
    apb(1'b1, ASR_OFS_CTRL, 8);
    u_asr_line_model.set_inv(1'b1);
    apb(1'b1, ASR_OFS_CTRL, 32'hd);
    one(8, 1'b1);
    apb(1'b1, ASR_OFS_CTRL, 32'h1d);
    one(9, 1'b1);
    one(9, 1'b0);
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
